// [design/bcbd_core.v]
// Bit set/clear/test, accumulator compares and jumps of a 4-bit core.
// Assumes program memory answers the PC with pm_data in the same cycle,
// and that the accumulator is driven by logic on core_clk.
// Data memory is not reset; a nibble must be written before it is tested.
`timescale 1ns/100ps
`include "bcbd_map.vh"

module bcbd_core (
    input  wire        core_clk,
    input  wire        rst_n,
    output reg  [3:0]  pc_page_part,
    output reg  [6:0]  pc_low_part,
    input  wire [8:0]  pm_data,
    input  wire [3:0]  acc,
    input  wire        ptr_load,
    input  wire [1:0]  ptr_x_in,
    input  wire [3:0]  ptr_y_in,
    input  wire        ptr_save,
    input  wire        ptr_restore,
    input  wire        mem_wr_en,
    input  wire [5:0]  mem_wr_addr,
    input  wire [3:0]  mem_wr_data,
    output reg  [5:0]  data_pointer,
    output reg  [3:0]  mem_view,
    output reg         skip_active,
    output wire        foreign_op
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam ST_FIRST  = 1'b0;
    localparam ST_SECOND = 1'b1;

    reg        state;
    reg [2:0]  kind;
    reg [3:0]  held_page;
    reg [1:0]  ptr_x;
    reg [3:0]  ptr_y;
    reg [1:0]  saved_x;
    reg [3:0]  saved_y;
    reg [3:0]  ram [0:`BCBD_RAM_WORDS-1];

    reg        next_state;
    reg [2:0]  next_kind;
    reg [3:0]  next_held_page;
    reg [3:0]  next_page;
    reg [6:0]  next_low;
    reg        next_skip;
    reg        ram_we;
    reg [3:0]  ram_wd;
    reg        is_other;
    reg [1:0]  next_ptr_x;
    reg [3:0]  next_ptr_y;
    reg [1:0]  next_saved_x;
    reg [3:0]  next_saved_y;

    wire [5:0] dp_addr = {ptr_x, ptr_y};
    wire [3:0] cur_nib = ram[dp_addr];
    wire [1:0] bit_sel = pm_data[1:0];
    wire [6:0] inc_low = pc_low_part + 7'h01;
    wire [3:0] bit_hit = 4'h1 << bit_sel;

    assign foreign_op = is_other;

    // ------------------------------------------------------------------
    // First-word opcode decode
    // ------------------------------------------------------------------
    wire       op_setf  = (pm_data[8:2] == `BCBD_OP_SETF);
    wire       op_clrf  = (pm_data[8:2] == `BCBD_OP_CLRF);
    wire       op_skz   = (pm_data[8:2] == `BCBD_OP_SKZ);
    wire       op_skip_if_acc_eq_mem  = (pm_data == `BCBD_OP_SKIP_IF_ACC_EQ_MEM);
    wire       op_seai  = (pm_data == `BCBD_OP_SEAI);
    wire       op_near  = (pm_data[8:7] == `BCBD_OP_NEAR);
    wire       op_far   = (pm_data[8:4] == `BCBD_OP_FAR);
    wire       op_nearx = (pm_data == `BCBD_OP_NEARX);
    wire       op_farx  = (pm_data == `BCBD_OP_FARX);
    // Opcodes that own the word after them
    wire       op_two   = op_seai | op_far | op_nearx | op_farx;

    // ------------------------------------------------------------------
    // Second-word fields
    // ------------------------------------------------------------------
    wire [3:0] w2_imm   = pm_data[3:0];
    wire [3:0] w2_page  = pm_data[`BCBD_PAGE_MSB:0];
    wire [6:0] w2_low   = pm_data[`BCBD_LOW_MSB:0];
    wire [6:0] w2_index = {pm_data[6:4], acc};

    // ------------------------------------------------------------------
    // Per-bit set, clear and test of the addressed nibble
    // ------------------------------------------------------------------
    wire [3:0] nib_set;
    wire [3:0] nib_clr;
    wire [3:0] nib_hit;

    // One cell per nibble bit; nib_hit keeps only the selected bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit
            assign nib_set[gi] = cur_nib[gi] | bit_hit[gi];
            assign nib_clr[gi] = cur_nib[gi] & ~bit_hit[gi];
            assign nib_hit[gi] = cur_nib[gi] & bit_hit[gi];
        end
    endgenerate

    wire       flag_zero = ~|nib_hit;

    // ------------------------------------------------------------------
    // Decode and execute
    // ------------------------------------------------------------------
    always @* begin
        next_state     = ST_FIRST;
        next_kind      = `BCBD_K_NONE;
        next_held_page = held_page;
        next_page      = pc_page_part;
        next_low       = inc_low;
        next_skip      = 1'b0;
        ram_we         = 1'b0;
        ram_wd         = cur_nib;
        is_other       = 1'b0;
        case (state)
            ST_FIRST: begin
                if (skip_active) begin
                    // Two-word opcodes swallow their tail too
                    if (op_two) begin
                        next_state = ST_SECOND;
                        next_kind  = `BCBD_K_SKIP;
                    end
                end else if (op_setf) begin
                    ram_we = 1'b1;
                    ram_wd = nib_set;
                end else if (op_clrf) begin
                    ram_we = 1'b1;
                    ram_wd = nib_clr;
                end else if (op_skz) begin
                    next_skip = flag_zero;
                end else if (op_skip_if_acc_eq_mem) begin
                    next_skip = (acc == cur_nib);
                end else if (op_seai) begin
                    next_state = ST_SECOND;
                    next_kind  = `BCBD_K_SEAI;
                end else if (op_near) begin
                    next_low = pm_data[`BCBD_LOW_MSB:0];
                end else if (op_far) begin
                    next_state     = ST_SECOND;
                    next_kind      = `BCBD_K_FAR;
                    next_held_page = pm_data[`BCBD_PAGE_MSB:0];
                end else if (op_nearx) begin
                    next_state = ST_SECOND;
                    next_kind  = `BCBD_K_NEARX;
                end else if (op_farx) begin
                    next_state = ST_SECOND;
                    next_kind  = `BCBD_K_FARX;
                end else begin
                    is_other = 1'b1;
                end
            end
            ST_SECOND: begin
                case (kind)
                    `BCBD_K_SEAI: begin
                        next_skip = (acc == w2_imm);
                    end
                    `BCBD_K_FAR: begin
                        next_page = held_page;
                        next_low  = w2_low;
                    end
                    `BCBD_K_NEARX: begin
                        next_low = w2_index;
                    end
                    `BCBD_K_FARX: begin
                        next_page = w2_page;
                        next_low  = w2_index;
                    end
                    `BCBD_K_SKIP: begin
                        // Tail of a skipped two-word opcode only moves the PC
                        next_skip = 1'b0;
                    end
                    default: begin
                        next_skip = 1'b0;
                    end
                endcase
            end
            default: begin
                next_state = ST_FIRST;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Instruction sequencing
    // ------------------------------------------------------------------
    // held_page keeps the far_jump page until its second word arrives
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_FIRST;
            kind      <= `BCBD_K_NONE;
            held_page <= `BCBD_RST_PAGE;
        end else begin
            state     <= next_state;
            kind      <= next_kind;
            held_page <= next_held_page;
        end
    end

    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_page_part <= `BCBD_RST_PAGE;
            pc_low_part  <= `BCBD_RST_LOW;
        end else begin
            pc_page_part <= next_page;
            pc_low_part  <= next_low;
        end
    end

    // ------------------------------------------------------------------
    // Skip status for the next fetched word
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_active <= 1'b0;
        end else begin
            skip_active <= next_skip;
        end
    end

    // ------------------------------------------------------------------
    // Pointer registers with interrupt save and restore
    // ------------------------------------------------------------------
    always @* begin
        next_ptr_x   = ptr_x;
        next_ptr_y   = ptr_y;
        next_saved_x = saved_x;
        next_saved_y = saved_y;
        // The save slot takes the pointer as it stood before this edge
        if (ptr_save) begin
            next_saved_x = ptr_x;
            next_saved_y = ptr_y;
        end
        if (ptr_restore) begin
            next_ptr_x = saved_x;
            next_ptr_y = saved_y;
        end else if (ptr_load) begin
            next_ptr_x = ptr_x_in;
            next_ptr_y = ptr_y_in;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_x        <= `BCBD_RST_X;
            ptr_y        <= `BCBD_RST_Y;
            saved_x      <= `BCBD_RST_X;
            saved_y      <= `BCBD_RST_Y;
            data_pointer <= {`BCBD_RST_X, `BCBD_RST_Y};
        end else begin
            ptr_x        <= next_ptr_x;
            ptr_y        <= next_ptr_y;
            saved_x      <= next_saved_x;
            saved_y      <= next_saved_y;
            data_pointer <= {next_ptr_x, next_ptr_y};
        end
    end

    // ------------------------------------------------------------------
    // Data memory; an instruction write wins over the side port
    // ------------------------------------------------------------------
    wire       wr_go   = ram_we | mem_wr_en;
    wire [5:0] wr_addr = ram_we ? dp_addr : mem_wr_addr;
    wire [3:0] wr_data = ram_we ? ram_wd : mem_wr_data;

    always @(posedge core_clk) begin
        if (wr_go) begin
            ram[wr_addr] <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Nibble view, one cycle behind the instruction that wrote it
    // ------------------------------------------------------------------
    wire [3:0] next_view = ram_we ? ram_wd : cur_nib;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_view <= `BCBD_RST_VIEW;
        end else begin
            mem_view <= next_view;
        end
    end

endmodule // bcbd_core

// [design/bcbd_map.vh]
// Constants for the bit, compare and branch decoder.
// Assumes 9-bit instruction words and a 64 x 4 data memory.
`ifndef BCBD_MAP_VH
`define BCBD_MAP_VH

// ----------------------------------------------------------------------
// Opcode patterns (matched on the listed high bits of the word)
// ----------------------------------------------------------------------
`define BCBD_OP_SETF      7'h17
`define BCBD_OP_CLRF      7'h13
`define BCBD_OP_SKZ       7'h08
`define BCBD_OP_SKIP_IF_ACC_EQ_MEM      9'h026
`define BCBD_OP_SEAI      9'h025
`define BCBD_OP_SEAI_2ND  5'h0B
`define BCBD_OP_NEAR      2'h3
`define BCBD_OP_FAR       5'h03
`define BCBD_OP_NEARX     9'h001
`define BCBD_OP_FARX      9'h010

// ----------------------------------------------------------------------
// Second-word kinds
// ----------------------------------------------------------------------
`define BCBD_K_NONE   3'h0
`define BCBD_K_SEAI   3'h1
`define BCBD_K_FAR    3'h2
`define BCBD_K_NEARX  3'h3
`define BCBD_K_FARX   3'h4
`define BCBD_K_SKIP   3'h5

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BCBD_PAGE_MSB   3
`define BCBD_LOW_MSB    6
`define BCBD_RST_PAGE   4'h0
`define BCBD_RST_LOW    7'h00
`define BCBD_RST_X      2'h0
`define BCBD_RST_Y      4'h0
`define BCBD_RST_VIEW   4'h0
`define BCBD_RAM_WORDS  64

`endif

// [sim/bcbd_checker.sv]
// Checker for bcbd_core: timing relations on its ports.
// Assumes one program word per cycle and no pointer change near checks.
`timescale 1ns/100ps
module bcbd_checker (
    input wire       core_clk,
    input wire       rst_n,
    input wire [3:0] pc_page_part,
    input wire [6:0] pc_low_part,
    input wire [8:0] pm_data,
    input wire [3:0] acc,
    input wire [3:0] mem_view,
    input wire       skip_active
);
    logic sec;
    wire  two = pm_data == 9'h025 || pm_data[8:4] == 5'h03 ||
                pm_data == 9'h001 || pm_data == 9'h010;
    // Live first word
    wire  f = !sec && !skip_active;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) sec <= 1'b0;
        else sec <= !sec && two;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    flag_wr_a: assert property (f && pm_data[8:5] == 4'h2 && pm_data[3:2] == 2'h3
        |=> mem_view[$past(pm_data[1:0])] == $past(pm_data[4])) else $error("flag write");
    flag_skip_a: assert property (f && pm_data[8:2] == 7'h08
        |=> skip_active == !$past(mem_view[pm_data[1:0]])) else $error("flag test");
    mem_cmp_a: assert property (f && pm_data == 9'h026
        |=> skip_active == ($past(acc) == $past(mem_view))) else $error("mem compare");
    imm_cmp_a: assert property (f && pm_data == 9'h025 ##1 1'b1
        |=> skip_active == ($past(acc) == $past(pm_data[3:0]))) else $error("imm compare");
    near_jump_a: assert property (f && pm_data[8:7] == 2'h3
        |=> $stable(pc_page_part) && pc_low_part == $past(pm_data[6:0])) else $error("near");
    far_jump_a: assert property (f && pm_data[8:4] == 5'h03 ##1 1'b1
        |=> pc_page_part == $past(pm_data[3:0], 2) && pc_low_part == $past(pm_data[6:0]))
        else $error("far");
    near_idx_a: assert property (f && pm_data == 9'h001 ##1 1'b1
        |=> $stable(pc_page_part) && pc_low_part == {$past(pm_data[6:4]), $past(acc)})
        else $error("near indexed");
    far_idx_a: assert property (f && pm_data == 9'h010 ##1 1'b1
        |=> pc_page_part == $past(pm_data[3:0]) && pc_low_part == {$past(pm_data[6:4]), $past(acc)})
        else $error("far indexed");
    skip_nop_a: assert property (skip_active && !sec
        |=> $stable(pc_page_part) && pc_low_part == $past(pc_low_part) + 7'h01) else $error("skip");
    cover property (f && pm_data == 9'h026 ##1 skip_active);
    cover property (f && pm_data[8:4] == 5'h03);
    cover property (skip_active && two);
endmodule // bcbd_checker
bind bcbd_core bcbd_checker u_bcbd_checker (.core_clk, .rst_n, .pc_page_part, .pc_low_part,
    .pm_data, .acc, .mem_view, .skip_active);

// [sim/bcbd_prog_rom.sv]
// Program memory model: answers the PC with a word in the same cycle.
// Assumes the bench writes each word before it is fetched.
`timescale 1ns/100ps
module bcbd_prog_rom (
    input  wire [3:0] pc_page_part,
    input  wire [6:0] pc_low_part,
    output wire [8:0] pm_data
);
    logic [8:0] mem [0:2047];
    assign pm_data = mem[{pc_page_part, pc_low_part}];
endmodule // bcbd_prog_rom

// [sim/bit_compare_branch_decode_bench.sv]
// Bench for bcbd_core with the program memory model.
// Assumes a combinational program memory and fixed-length scenarios.
`timescale 1ns/100ps
module bit_compare_branch_decode_bench;
    logic        core_clk = 1'b0, rst_n = 1'b0, ptr_load = 1'b0, ptr_save = 1'b0;
    logic        ptr_restore = 1'b0, mem_wr_en = 1'b0;
    logic [1:0]  ptr_x_in = 2'h0;
    logic [3:0]  ptr_y_in = 4'h0, acc = 4'h0, mem_wr_data = 4'h0;
    logic [5:0]  mem_wr_addr = 6'h00;
    logic [10:0] pa = 11'h000;
    wire  [3:0]  pc_page_part, mem_view;
    wire  [6:0]  pc_low_part;
    wire  [8:0]  pm_data;
    wire  [5:0]  data_pointer;
    wire         skip_active, foreign_op;
    int          num_errors = 0, checks_done = 0;
    initial forever #5 core_clk = ~core_clk;
    bcbd_core u_bcbd_core (.core_clk, .rst_n, .pc_page_part, .pc_low_part, .pm_data, .acc,
        .ptr_load, .ptr_x_in, .ptr_y_in, .ptr_save, .ptr_restore, .mem_wr_en, .mem_wr_addr,
        .mem_wr_data, .data_pointer, .mem_view, .skip_active, .foreign_op);
    bcbd_prog_rom u_bcbd_prog_rom (.pc_page_part, .pc_low_part, .pm_data);
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [10:0] inc();
        return {pa[10:7], pa[6:0] + 7'h01};
    endfunction
    // Place a word at the expected PC, run one cycle, compare the new PC
    task automatic step(input logic [8:0] w, input logic [10:0] nxt);
        u_bcbd_prog_rom.mem[pa] = w;
        @(posedge core_clk);
        #1;
        pa = nxt;
        chk({pc_page_part, pc_low_part}, pa);
    endtask
    task automatic t_ptr();
        u_bcbd_prog_rom.mem[pa] = 9'h000;
        #1 chk(foreign_op, 1'b1);
        {ptr_x_in, ptr_y_in, ptr_load} = {6'h15, 1'b1};
        step(9'h000, inc());
        {ptr_load, ptr_save} = 2'b01;
        step(9'h000, inc());
        {ptr_save, ptr_x_in, ptr_load} = {1'b0, 2'h2, 1'b1};
        step(9'h000, inc());
        chk(data_pointer, 6'h25);
        {ptr_load, ptr_restore} = 2'b01;
        step(9'h000, inc());
        {ptr_restore, mem_wr_addr, mem_wr_en} = {1'b0, 6'h15, 1'b1};
        chk(data_pointer, 6'h15);
        step(9'h000, inc());
        mem_wr_en = 1'b0;
    endtask
    task automatic t_bits();
        for (int j = 0; j < 4; j++) begin
            u_bcbd_prog_rom.mem[pa] = {7'h17, j[1:0]};
            #1 chk(foreign_op, 1'b0);
            step({7'h17, j[1:0]}, inc());
            chk(mem_view, 4'hF >> (3 - j));
        end
        step(9'h04E, inc());
        chk(mem_view, 4'hB);
        step(9'h022, inc());
        chk(skip_active, 1'b1);
        step(9'h1FF, inc());
        step(9'h020, inc());
        step(9'h1C0, {pa[10:7], 7'h40});
    endtask
    task automatic t_cmp();
        acc = 4'hB;
        step(9'h026, inc());
        chk(skip_active, 1'b1);
        step(9'h035, inc());
        step(9'h192, inc());
        step(9'h025, inc());
        step(9'h0BB, inc());
        step(9'h1C5, inc());
        step(9'h025, inc());
        step(9'h0BA, inc());
        step(9'h1C5, {pa[10:7], 7'h45});
    endtask
    task automatic t_jump();
        for (int p = 0; p < 16; p++) begin
            step({5'h03, p[3:0]}, inc());
            step({2'h3, 7'h12 + p[6:0]}, {p[3:0], 7'h12 + p[6:0]});
        end
        acc = 4'h9;
        step(9'h001, inc());
        step(9'h1DF, {pa[10:7], 7'h59});
        step(9'h010, inc());
        step(9'h1BC, {4'hC, 7'h39});
    endtask
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_ptr();
        t_bits();
        t_cmp();
        t_jump();
        end_sim();
    end
endmodule // bit_compare_branch_decode_bench
